// File: core/csc_pkg.sv
// Constants for the capacitive sensing control and sleep block
package csc_pkg;
    localparam logic [1:0] CSC_ADDR_CONTROL_0   = 2'h0;
    localparam logic [1:0] CSC_ADDR_TIMER1_CTRL = 2'h1;
    localparam logic [1:0] CSC_ADDR_GATE_CTRL   = 2'h2;
    localparam logic [1:0] CSC_ADDR_TIMER_STAT  = 2'h3;
    localparam int  CSC_ADDR_W      = 2;
    localparam int  CSC_DATA_W      = 8;
    localparam int  CSC_TMR_W       = 16;
    // Control register 0 fields
    localparam int  CSC_BIT_ENABLE   = 7;
    localparam int  CSC_BIT_RANGE_HI = 3;
    localparam int  CSC_BIT_RANGE_LO = 2;
    localparam int  CSC_BIT_DIR      = 1;
    localparam int  CSC_BIT_T0_CHOICE = 0;
    localparam logic [7:0] CSC_CTRL0_WMASK = 8'h8D;
    localparam logic [7:0] CSC_CTRL0_RESET = 8'h00;
    // Timer1 control fields
    localparam int  CSC_BIT_T1CS_HI  = 7;
    localparam int  CSC_BIT_T1CS_LO  = 6;
    localparam int  CSC_BIT_T1ON     = 0;
    localparam logic [7:0] CSC_T1CTRL_RESET = 8'h00;
    // Gate control fields
    localparam int  CSC_BIT_GATE_EN  = 7;
    localparam int  CSC_BIT_TOGGLE   = 6;
    localparam int  CSC_BIT_GATE_OPEN = 2;
    localparam int  CSC_BIT_GSS_HI   = 1;
    localparam int  CSC_BIT_GSS_LO   = 0;
    localparam logic [7:0] CSC_GATE_WMASK = 8'hC3;
    localparam logic [7:0] CSC_GATE_RESET = 8'h00;
    localparam logic [1:0] CSC_SRC_SENSE_OSC = 2'h3;
    localparam logic [1:0] CSC_GSS_WATCHDOG  = 2'h3;
    localparam logic [1:0] CSC_RANGE_OFF     = 2'h0;
    typedef enum logic [1:0] {
        CSC_RANGE_OFF_E, CSC_RANGE_LOW, CSC_RANGE_MED, CSC_RANGE_HIGH
    } csc_range_type;
endpackage

// File: core/csc_sense_ctrl.sv
// Capacitive sensing control register and watchdog-gated Timer1 counting
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Function
// RL1: Oscillator runs whenever module enabled, sleeping or not. The code also keeps it stopped while range is 00.
// RL2: Timer1 accumulates oscillator counts during sleep.
// RL3: Gate source field 11 routes watchdog overflow to Timer1 gate.
// RL4: Software sets toggle mode, then gate enable, then Timer1 on.
// RL5: Software enables sensing, clears Timer1, then sleeps.
// RL6: First watchdog overflow opens gate; Timer1 starts counting.
// RL7: Second watchdog overflow closes gate; count held.
// RL8: Early non-watchdog wake delays next watchdog overflow.
// RL9: Timer0 does not count during sleep.
// RL10: Bits 6..4 read zero; enable bit 7 resets to zero.
// RL11: Range 00 off, 01 low, 10 medium, 11 high.
// RL12: Bit 1 reads oscillator direction: 1 sourcing, 0 sinking.
// RL13: Bit 0 picks Timer0 clock when external select is high.
// RL14: Timer1 clock source 11 selects sensing oscillator.
module csc_sense_ctrl (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_reset_n,
    input  wire logic [csc_pkg::CSC_ADDR_W-1:0] i_addr,
    input  wire logic [csc_pkg::CSC_DATA_W-1:0] i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    input  wire logic                        i_sleep,
    input  wire logic                        i_osc_sourcing,
    input  wire logic                        i_osc_edge,
    input  wire logic                        i_watchdog_ovf,
    input  wire logic                        i_timer0_ext_clock_sel,
    input  wire logic                        i_timer0_clock_pin,
    input  wire logic                        i_instr_clk_en,
    output logic [csc_pkg::CSC_DATA_W-1:0]   o_rdata,
    output logic                             o_osc_run,
    output logic [1:0]                       o_osc_current_range,
    output logic                             o_watchdog_restart,
    output logic                             o_timer0_tick
);
    import csc_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [7:0]           ctrl0, next_ctrl0;
    logic [7:0]           t1ctrl, next_t1ctrl;
    logic                 gate_en, next_gate_en;
    logic                 toggle, next_toggle;
    logic [1:0]           gss, next_gss;
    logic                 gate_open, next_gate_open;
    logic [CSC_TMR_W-1:0] tmr1, next_tmr1;
    logic                 sleep_q, next_sleep_q;
    logic [7:0]           rdata, next_rdata;
    logic                 osc_run, next_osc_run;
    logic [1:0]           range_q, next_range_q;
    logic                 wd_rst, next_wd_rst;
    logic                 t0_tick, next_t0_tick;

    logic sense_en;
    logic wd_gate_evt;
    logic t1_src_osc;
    logic t1_count;
    logic t0_src;

    function automatic logic bus_wr(input logic [CSC_ADDR_W-1:0] a);
        bus_wr = i_wr && (i_addr == a);
    endfunction

    assign sense_en    = ctrl0[CSC_BIT_ENABLE];
    assign t1_src_osc  = (t1ctrl[CSC_BIT_T1CS_HI:CSC_BIT_T1CS_LO]
                          == CSC_SRC_SENSE_OSC);                  // [RL14]
    assign wd_gate_evt = i_watchdog_ovf && (gss == CSC_GSS_WATCHDOG); // [RL3]
    // Gate only gates when enabled; oscillator edges counted in sleep
    assign t1_count = t1ctrl[CSC_BIT_T1ON] && t1_src_osc && sense_en
                      && i_osc_edge && (!gate_en || gate_open); // [RL2]

    // ****************************************************************
    // Timer0 clock choice
    // ****************************************************************
    always_comb begin
        if (i_timer0_ext_clock_sel) begin
            t0_src = ctrl0[CSC_BIT_T0_CHOICE] ?
                     (i_osc_edge && sense_en) : i_timer0_clock_pin; // [RL13]
        end else begin
            t0_src = i_instr_clk_en;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_ctrl0     = ctrl0;
        next_t1ctrl    = t1ctrl;
        next_gate_en   = gate_en;
        next_toggle    = toggle;
        next_gss       = gss;
        next_gate_open = gate_open;
        next_tmr1      = tmr1;
        next_sleep_q   = i_sleep;
        next_rdata     = '0;
        if (bus_wr(CSC_ADDR_CONTROL_0)) begin
            next_ctrl0 = i_wdata & CSC_CTRL0_WMASK;               // [RL10]
        end
        if (bus_wr(CSC_ADDR_TIMER1_CTRL)) begin
            next_t1ctrl = i_wdata;
        end
        if (bus_wr(CSC_ADDR_GATE_CTRL)) begin
            next_gate_en = i_wdata[CSC_BIT_GATE_EN];
            next_toggle  = i_wdata[CSC_BIT_TOGGLE];
            next_gss     = i_wdata[CSC_BIT_GSS_HI:CSC_BIT_GSS_LO];
            if (!i_wdata[CSC_BIT_TOGGLE]) begin
                next_gate_open = 1'b0;
            end
        end
        // In toggle mode with Timer1 on, watchdog overflow toggles the gate: open then close; without toggle it only opens it
        if (wd_gate_evt && toggle && t1ctrl[CSC_BIT_T1ON]) begin
            next_gate_open = !gate_open;                   // [RL6] [RL7]
        end else if (wd_gate_evt && !toggle) begin
            next_gate_open = 1'b1;
        end
        if (bus_wr(CSC_ADDR_TIMER_STAT)) begin
            next_tmr1 = '0;                                       // [RL5]
        end else if (t1_count) begin
            next_tmr1 = tmr1 + 1'b1;                              // [RL2]
        end
        if (i_rd) begin
            unique case (i_addr)
                CSC_ADDR_CONTROL_0: begin
                    next_rdata = (ctrl0 & CSC_CTRL0_WMASK)
                        | {6'h00, i_osc_sourcing && sense_en, 1'b0}; // [RL12]
                end
                CSC_ADDR_TIMER1_CTRL: next_rdata = t1ctrl;
                CSC_ADDR_GATE_CTRL: begin
                    next_rdata = {gate_en, toggle, 3'h0, gate_open, gss};
                end
                CSC_ADDR_TIMER_STAT: next_rdata = tmr1[7:0];
            endcase
        end
        next_osc_run = sense_en                                   // [RL1]
            && (ctrl0[CSC_BIT_RANGE_HI:CSC_BIT_RANGE_LO] != CSC_RANGE_OFF);
        next_range_q = ctrl0[CSC_BIT_RANGE_HI:CSC_BIT_RANGE_LO]; // [RL11]
        // Wake without watchdog restarts its interval
        next_wd_rst  = sleep_q && !i_sleep && !i_watchdog_ovf; // [RL8]
        next_t0_tick = t0_src && !i_sleep;                     // [RL9]
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl0     <= CSC_CTRL0_RESET;
            t1ctrl    <= CSC_T1CTRL_RESET;
            gate_en   <= 1'b0;
            toggle    <= 1'b0;
            gss       <= 2'h0;
            gate_open <= 1'b0;
            tmr1      <= '0;
            sleep_q   <= 1'b0;
            rdata     <= 8'h00;
            osc_run   <= 1'b0;
            range_q   <= 2'h0;
            wd_rst    <= 1'b0;
            t0_tick   <= 1'b0;
        end else begin
            ctrl0     <= next_ctrl0;
            t1ctrl    <= next_t1ctrl;
            gate_en   <= next_gate_en;
            toggle    <= next_toggle;
            gss       <= next_gss;
            gate_open <= next_gate_open;
            tmr1      <= next_tmr1;
            sleep_q   <= next_sleep_q;
            rdata     <= next_rdata;
            osc_run   <= next_osc_run;
            range_q   <= next_range_q;
            wd_rst    <= next_wd_rst;
            t0_tick   <= next_t0_tick;
        end
    end

    assign o_rdata             = rdata;
    assign o_osc_run           = osc_run;
    assign o_osc_current_range = range_q;
    assign o_watchdog_restart  = wd_rst;
    assign o_timer0_tick       = t0_tick;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    AST_OSC_RUNS_IN_SLEEP: assert property ( // [RL1]
        (sense_en && ctrl0[3:2] != 2'h0 && i_sleep) |=> o_osc_run)
        else $error("oscillator stopped while enabled in sleep");
    AST_T1_COUNTS_SLEEP: assert property ( // [RL2]
        (t1_count && i_sleep && !bus_wr(CSC_ADDR_TIMER_STAT))
        |=> tmr1 == $past(tmr1) + 16'h0001)
        else $error("timer1 missed an edge in sleep");
    AST_GSS_ROUTE: assert property ( // [RL3]
        (i_watchdog_ovf && gss != 2'h3) |=> gate_open == $past(gate_open)
        || $past(bus_wr(CSC_ADDR_GATE_CTRL)))
        else $error("gate moved without watchdog source");
    AST_GATE_OPEN: assert property ( // [RL6]
        (wd_gate_evt && toggle && t1ctrl[0] && !gate_open
         && !bus_wr(CSC_ADDR_GATE_CTRL)) |=> gate_open)
        else $error("first overflow did not open gate");
    AST_GATE_CLOSE_HOLD: assert property ( // [RL7]
        (wd_gate_evt && toggle && t1ctrl[0] && gate_open && gate_en
         && !bus_wr(CSC_ADDR_GATE_CTRL)) |=> ##1 $stable(tmr1)
         || $past(bus_wr(CSC_ADDR_TIMER_STAT)))
        else $error("timer1 kept counting after gate closed");
    AST_EARLY_WAKE: assert property ( // [RL8]
        ($fell(i_sleep) && !i_watchdog_ovf) |=> o_watchdog_restart)
        else $error("early wake did not restart watchdog");
    AST_T0_SLEEP: assert property ( // [RL9]
        i_sleep |=> !o_timer0_tick)
        else $error("timer0 ticked in sleep");
    AST_RESERVED_ZERO: assert property ( // [RL10]
        $past(i_rd) |-> o_rdata[6:4] == 3'h0 || $past(i_addr) != 2'h0)
        else $error("reserved bits read nonzero");
    AST_RANGE_OUT: assert property ( // [RL11]
        ##1 o_osc_current_range == $past(ctrl0[3:2]))
        else $error("range output mismatch");
    AST_DIR_READ: assert property ( // [RL12]
        (i_rd && i_addr == 2'h0 && sense_en)
        |=> o_rdata[1] == $past(i_osc_sourcing))
        else $error("direction status wrong");
    AST_T0_PIN: assert property ( // [RL13]
        (i_timer0_ext_clock_sel && !ctrl0[0] && !i_sleep)
        |=> o_timer0_tick == $past(i_timer0_clock_pin))
        else $error("timer0 pin source not used");
    AST_T1_SRC: assert property ( // [RL14]
        (!t1_src_osc && !bus_wr(CSC_ADDR_TIMER_STAT)) |=> $stable(tmr1))
        else $error("timer1 counted without oscillator source");

    COV_FULL_GATE: cover property (
        wd_gate_evt && toggle && !gate_open ##[1:200] wd_gate_evt && gate_open);
    COV_SLEEP_COUNT: cover property (t1_count && i_sleep);
    COV_EARLY_WAKE: cover property (o_watchdog_restart);
endmodule

// File: test/csc_osc_model.sv
// Sensing oscillator model feeding edge pulses and direction
`timescale 1ns/1ps
module csc_osc_model (
    input  wire logic i_clk_sys,
    input  wire logic i_reset_n,
    input  wire logic i_run,
    input  wire logic i_free,
    output logic      o_edge,
    output logic      o_sourcing
);
    logic ph;
    int   pend;
    // Edges only while enabled, sleep or not; direction flips per edge
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_edge     <= 1'b0;
            o_sourcing <= 1'b0;
            ph         <= 1'b0;
            pend       <= 0;
        end else begin
            ph <= ~ph;
            if (i_run && ph && (i_free || pend > 0)) begin
                o_edge     <= 1'b1;
                o_sourcing <= ~o_sourcing;
                if (pend > 0) pend <= pend - 1;
            end else begin
                o_edge <= 1'b0;
            end
        end
    end
    // Exact number of edges, then still
    task automatic burst(input int n);
        @(negedge i_clk_sys);
        pend = n;
        repeat (2 * n + 4) @(posedge i_clk_sys);
    endtask
endmodule

// File: test/tb_top.sv
// Self-checking testbench for the sensing control block
`timescale 1ns/1ps
module tb_top;
    import csc_pkg::*;
    logic       clk, rst_n, wr, rd, slp, wdt, t0sel, pin, instr, free;
    logic       run, rstart, t0tick, osc_edge, src;
    logic [1:0] addr, rng;
    logic [7:0] wdata, rdata, cyc;
    int         n_errors, n_tests, t0_cnt, rs_cnt;

    csc_sense_ctrl u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_sleep(slp),
        .i_osc_sourcing(src), .i_osc_edge(osc_edge), .i_watchdog_ovf(wdt),
        .i_timer0_ext_clock_sel(t0sel), .i_timer0_clock_pin(pin),
        .i_instr_clk_en(instr), .o_rdata(rdata), .o_osc_run(run),
        .o_osc_current_range(rng), .o_watchdog_restart(rstart),
        .o_timer0_tick(t0tick));
    csc_osc_model u_osc (.i_clk_sys(clk), .i_reset_n(rst_n), .i_run(run),
        .i_free(free), .o_edge(osc_edge), .o_sourcing(src));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc   <= cyc + 8'h01;
        instr <= (cyc[1:0] == 2'h0);
        pin   <= (cyc[2:0] == 3'h3);
        if (t0tick === 1'b1) t0_cnt++;
        if (rstart === 1'b1) rs_cnt++;
    end

    task automatic chk(input string nm, input logic [7:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [1:0] a,
                          input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(nm, rdata, e);
    endtask
    task automatic pulse_wdt();
        @(posedge clk) wdt <= 1'b1;
        @(posedge clk) wdt <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_ranges();
        rd_chk("ctrl0 reset", CSC_ADDR_CONTROL_0, 8'h00);
        for (int r = 0; r < 4; r++) begin
            wr_reg(CSC_ADDR_CONTROL_0, 8'hF1 | 8'(r << 2));
            repeat (2) @(posedge clk);
            #1 chk("range", {6'h0, rng}, 8'(r));
            chk("run", {7'h0, run}, {7'h0, r != 0});
            rd_chk("ctrl0", CSC_ADDR_CONTROL_0,
                   8'h81 | 8'(r << 2) | {6'h0, src, 1'b0});
        end
        wr_reg(CSC_ADDR_CONTROL_0, 8'h0C);
        repeat (2) @(posedge clk);
        #1 chk("run off", {7'h0, run}, 8'h00);
        wr_reg(CSC_ADDR_CONTROL_0, 8'h84);
        u_osc.burst(1);
        rd_chk("dir", CSC_ADDR_CONTROL_0, 8'h84|{6'h0, src, 1'b0});
    endtask
    task automatic t0_case(input logic sel, ch, sl, input int lo, hi);
        wr_reg(CSC_ADDR_CONTROL_0, 8'h84 | {7'h0, ch});
        t0sel <= sel;
        slp   <= sl;
        repeat (4) @(posedge clk);
        @(negedge clk) t0_cnt = 0;
        repeat (40) @(posedge clk);
        #1 chk("t0", 8'(t0_cnt >= lo && t0_cnt <= hi), 8'h01);
    endtask
    task automatic sc_timer0();
        free <= 1'b1;
        t0_case(1'b1, 1'b1, 1'b0, 19, 21);
        t0_case(1'b1, 1'b0, 1'b0, 4, 6);
        t0_case(1'b0, 1'b1, 1'b0, 9, 11);
        t0_case(1'b0, 1'b1, 1'b1, 0, 0);
        free <= 1'b0;
        slp  <= 1'b0;
    endtask
    task automatic sc_sleep_meas();
        wr_reg(CSC_ADDR_GATE_CTRL, 8'h03);
        wr_reg(CSC_ADDR_GATE_CTRL, 8'h43);
        wr_reg(CSC_ADDR_GATE_CTRL, 8'hC3);
        wr_reg(CSC_ADDR_TIMER1_CTRL, 8'hC1);
        wr_reg(CSC_ADDR_CONTROL_0, 8'h84);
        wr_reg(CSC_ADDR_TIMER_STAT, 8'h00);
        slp <= 1'b1;
        u_osc.burst(3);
        rd_chk("closed", CSC_ADDR_TIMER_STAT, 8'h00);
        pulse_wdt();
        rd_chk("gate open", CSC_ADDR_GATE_CTRL, 8'hC7);
        u_osc.burst(13);
        #1 chk("run asleep", {7'h0, run}, 8'h01);
        pulse_wdt();
        u_osc.burst(5);
        rd_chk("count", CSC_ADDR_TIMER_STAT, 8'h0D);
        rd_chk("gate shut", CSC_ADDR_GATE_CTRL, 8'hC3);
    endtask
    task automatic sc_wake();
        repeat (3) @(posedge clk);
        @(negedge clk) rs_cnt = 0;
        @(posedge clk) slp <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("early wake", 8'(rs_cnt), 8'h01);
        @(posedge clk) slp <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk) rs_cnt = 0;
        @(posedge clk);
        slp <= 1'b0;
        wdt <= 1'b1;
        @(posedge clk) wdt <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk("wdt wake", 8'(rs_cnt), 8'h00);
    endtask
    // Gate ignores overflow off its source; timer needs oscillator source
    task automatic sc_gate_src();
        wr_reg(CSC_ADDR_GATE_CTRL, 8'hC0);
        pulse_wdt();
        rd_chk("gate held", CSC_ADDR_GATE_CTRL, 8'hC4);
        wr_reg(CSC_ADDR_GATE_CTRL, 8'h00);
        wr_reg(CSC_ADDR_TIMER1_CTRL, 8'h01);
        wr_reg(CSC_ADDR_TIMER_STAT, 8'h00);
        u_osc.burst(4);
        rd_chk("no osc src", CSC_ADDR_TIMER_STAT, 8'h00);
        wr_reg(CSC_ADDR_TIMER1_CTRL, 8'hC1);
        u_osc.burst(4);
        rd_chk("osc src", CSC_ADDR_TIMER_STAT, 8'h04);
    endtask

    task automatic conclude();
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        conclude();
    end
    initial begin
        {rst_n, wr, rd, slp, wdt, t0sel, pin, instr, free} = 9'h000;
        {addr, wdata, cyc, n_errors, n_tests, t0_cnt, rs_cnt} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        sc_ranges();
        sc_timer0();
        sc_sleep_meas();
        sc_wake();
        sc_gate_src();
        conclude();
    end
endmodule
